// ===== rtl/tick_irq_pkg.sv
package tick_irq_pkg;
  localparam int unsigned NUM_SRC = 8;
  localparam int unsigned NUM_GRP = 4;
  localparam int unsigned NUM_TICK = 2;
  localparam int unsigned TICK_CNT_W = 15;
  localparam int unsigned DIV4_W = 2;
  localparam int unsigned PERIOD_BASE = 8;

  // Byte addresses of the byte-wide registers, one per word
  localparam logic [7:0] ADR_TICK0_SRC = 8'h00;
  localparam logic [7:0] ADR_TICK1_SRC = 8'h04;
  localparam logic [7:0] ADR_TICK0_CTL = 8'h08;
  localparam logic [7:0] ADR_TICK1_CTL = 8'h0C;
  localparam logic [7:0] ADR_SRC_FLAG = 8'h10;
  localparam logic [7:0] ADR_SRC_EN = 8'h14;
  localparam logic [7:0] ADR_GRP_FLAG = 8'h18;
  localparam logic [7:0] ADR_GRP_EN = 8'h1C;
  localparam logic [7:0] ADR_GLOBAL = 8'h20;

  // Source bit positions, shared by flag and enable registers
  localparam int unsigned SRC_MATCH_A = 0;
  localparam int unsigned SRC_MATCH_P = 1;
  localparam int unsigned SRC_CMP = 2;
  localparam int unsigned SRC_TICK0 = 3;
  localparam int unsigned SRC_TICK1 = 4;
  localparam int unsigned SRC_LV = 5;
  localparam int unsigned SRC_NVM = 6;
  localparam int unsigned SRC_SERIAL = 7;

  // Members of each group, group 0 in the low byte
  localparam logic [NUM_GRP-1:0][NUM_SRC-1:0] GRP_MEMBERS = {8'hE0, 8'h18, 8'h04, 8'h03};

  localparam int unsigned CTL_RUN_BIT = 7;
  localparam int unsigned SRC_SEL_W = 2;
  localparam int unsigned PERIOD_W = 3;
  localparam int unsigned GLOBAL_EN_BIT = 0;

  localparam logic [1:0] SEL_SYS = 2'h0;
  localparam logic [1:0] SEL_SYS_DIV4 = 2'h1;

  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [DIV4_W-1:0] DIV4_LAST = 2'h3;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic match_a;
    logic match_p;
    logic nvm_done;
    logic byte_done;
    logic addr_match;
    logic bus_timeout;
  } src_events_t;
endpackage

// ===== rtl/tick_irq_ctrl.sv
`timescale 1ns/1ps
// Function
// - Timer has separate match A/P flags, enables
// - Vector needs global, source, group enable, stack
// - Service clears global and group, not source
// - Timer matches vector via group 0; irq output bypasses groups
// - Comparator flag set on either output edge
// - Tick flag set on divider overflow
// - Prescaler source: sys, sys/4, subclock
// - Control bit 7 runs tick generator
// - Tick0 period 2^8..2^15 prescaled cycles
// - Tick1 period 2^8..2^15 prescaled cycles
// - Low-voltage flag set on supply drop
// - Memory flag set at erase/write end
// - Serial flag on byte, address, timeout
// - Unused control bits read zero
// - Group flag set by member source flag
// - Flag rising edge wakes, enabled or not
module tick_irq_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire tick_irq_pkg::wb_req_t wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat_o,
  input wire tick_irq_pkg::src_events_t src_events,
  input wire logic cmp_out,
  input wire logic low_voltage,
  input wire logic low_speed_subclk,
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic [1:0] irq_ack_group,
  input wire logic irq_return,
  output logic irq_req,
  output logic [1:0] irq_group,
  output logic wake,
  output logic irq
);
  import tick_irq_pkg::*;

  // Mask of the low bits that must all be ones at overflow
  function automatic logic [TICK_CNT_W-1:0] period_mask(input logic [PERIOD_W-1:0] sel);
    logic [TICK_CNT_W:0] one_hot;
    one_hot = '0;
    one_hot[PERIOD_BASE + 32'(sel)] = 1'b1;
    period_mask = TICK_CNT_W'(one_hot - 1'b1);
  endfunction

  logic [7:0] clk_src_ff [NUM_TICK];
  logic [7:0] tick_ctl_ff [NUM_TICK];
  logic [TICK_CNT_W-1:0] tick_cnt_ff [NUM_TICK];
  logic [NUM_SRC-1:0] src_flag_ff;
  logic [NUM_SRC-1:0] src_en_ff;
  logic [NUM_GRP-1:0] grp_flag_ff;
  logic [NUM_GRP-1:0] grp_en_ff;
  logic global_en_ff;
  logic [DIV4_W-1:0] div4_ff;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [2:0] stable_ff;
  logic wb_ack_ff;
  logic [31:0] rd_dat_ff;
  logic wake_ff;
  logic irq_ff;

  // Bus decode
  wire bus_req = wb_req.cyc & wb_req.stb & ~wb_ack_ff;
  wire wr_lane0 = bus_req & wb_req.we & wb_req.sel[0];
  wire [7:0] wdat = wb_req.dat[7:0];
  wire wr_src_flag = wr_lane0 & (wb_req.adr == ADR_SRC_FLAG);
  wire wr_src_en = wr_lane0 & (wb_req.adr == ADR_SRC_EN);
  wire wr_grp_flag = wr_lane0 & (wb_req.adr == ADR_GRP_FLAG);
  wire wr_grp_en = wr_lane0 & (wb_req.adr == ADR_GRP_EN);
  wire wr_global = wr_lane0 & (wb_req.adr == ADR_GLOBAL);
  wire [NUM_TICK-1:0] wr_clk_src;
  wire [NUM_TICK-1:0] wr_tick_ctl;
  assign wr_clk_src[0] = wr_lane0 & (wb_req.adr == ADR_TICK0_SRC);
  assign wr_clk_src[1] = wr_lane0 & (wb_req.adr == ADR_TICK1_SRC);
  assign wr_tick_ctl[0] = wr_lane0 & (wb_req.adr == ADR_TICK0_CTL);
  assign wr_tick_ctl[1] = wr_lane0 & (wb_req.adr == ADR_TICK1_CTL);

  // Only the implemented bits are stored, the rest read zero
  wire [7:0] clk_src_keep = 8'((1 << SRC_SEL_W) - 1);
  wire [7:0] ctl_keep = 8'(1 << CTL_RUN_BIT) | 8'((1 << PERIOD_W) - 1);

  // Pin synchronisers: comparator, low voltage, subclock
  wire [2:0] pins = {low_speed_subclk, low_voltage, cmp_out};
  wire [2:0] agree = ~(sync2_ff ^ sync3_ff);
  wire [2:0] nxt_stable = (agree & sync3_ff) | (~agree & stable_ff);
  wire cmp_toggle = nxt_stable[0] ^ stable_ff[0];
  wire lv_rise = nxt_stable[1] & ~stable_ff[1];
  wire sub_rise = nxt_stable[2] & ~stable_ff[2];

  // Prescaled clock enables
  wire div4_tick = (div4_ff == DIV4_LAST);
  wire [NUM_TICK-1:0] psc_tick;
  wire [NUM_TICK-1:0] tick_run;
  wire [NUM_TICK-1:0] tick_ovf;
  wire [TICK_CNT_W-1:0] tick_mask [NUM_TICK];
  for (genvar t = 0; t < NUM_TICK; t++) begin : g_tick
    wire [1:0] ssel = clk_src_ff[t][SRC_SEL_W-1:0];
    assign psc_tick[t] = (ssel == SEL_SYS) ? 1'b1 :
                         (ssel == SEL_SYS_DIV4) ? div4_tick : sub_rise;
    assign tick_run[t] = tick_ctl_ff[t][CTL_RUN_BIT];
    assign tick_mask[t] = period_mask(tick_ctl_ff[t][PERIOD_W-1:0]);
    assign tick_ovf[t] = tick_run[t] & psc_tick[t] &
                         ((tick_cnt_ff[t] & tick_mask[t]) == tick_mask[t]);
  end

  // Source set events
  wire serial_evt = src_events.byte_done | src_events.addr_match | src_events.bus_timeout;
  wire [NUM_SRC-1:0] src_set;
  assign src_set[SRC_MATCH_A] = src_events.match_a;
  assign src_set[SRC_MATCH_P] = src_events.match_p;
  assign src_set[SRC_CMP] = cmp_toggle;
  assign src_set[SRC_TICK0] = tick_ovf[0];
  assign src_set[SRC_TICK1] = tick_ovf[1];
  assign src_set[SRC_LV] = lv_rise;
  assign src_set[SRC_NVM] = src_events.nvm_done;
  assign src_set[SRC_SERIAL] = serial_evt;

  // Set wins over a software clear in the same cycle
  wire [NUM_SRC-1:0] src_clr = wr_src_flag ? wdat : '0;
  wire [NUM_SRC-1:0] nxt_src_flag = (src_flag_ff & ~src_clr) | src_set;

  // Group flags and vectoring
  wire [NUM_SRC-1:0] src_active = src_flag_ff & src_en_ff;
  wire [NUM_GRP-1:0] grp_set;
  wire [NUM_GRP-1:0] grp_pend;
  for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
    assign grp_set[g] = |(src_set & GRP_MEMBERS[g]);
    assign grp_pend[g] = grp_flag_ff[g] & grp_en_ff[g] & |(src_active & GRP_MEMBERS[g]);
  end
  wire [NUM_GRP-1:0] grp_ack = irq_ack ? NUM_GRP'(1) << irq_ack_group : '0;
  wire [NUM_GRP-1:0] grp_clr = grp_ack | (wr_grp_flag ? wdat[NUM_GRP-1:0] : '0);
  wire [NUM_GRP-1:0] nxt_grp_flag = (grp_flag_ff & ~grp_clr) | grp_set;

  // Return from service re-enables; a service clears
  wire nxt_global_en = irq_return ? 1'b1 :
                       irq_ack ? 1'b0 :
                       wr_global ? wdat[GLOBAL_EN_BIT] : global_en_ff;

  assign irq_req = global_en_ff & ~stack_full & |grp_pend;
  // Lowest group number has the highest priority
  assign irq_group = grp_pend[0] ? 2'h0 :
                     grp_pend[1] ? 2'h1 :
                     grp_pend[2] ? 2'h2 : 2'h3;

  // Read mux, unmapped addresses answer zero
  wire [7:0] rd_byte =
    (wb_req.adr == ADR_TICK0_SRC) ? clk_src_ff[0] :
    (wb_req.adr == ADR_TICK1_SRC) ? clk_src_ff[1] :
    (wb_req.adr == ADR_TICK0_CTL) ? tick_ctl_ff[0] :
    (wb_req.adr == ADR_TICK1_CTL) ? tick_ctl_ff[1] :
    (wb_req.adr == ADR_SRC_FLAG) ? src_flag_ff :
    (wb_req.adr == ADR_SRC_EN) ? src_en_ff :
    (wb_req.adr == ADR_GRP_FLAG) ? 8'(grp_flag_ff) :
    (wb_req.adr == ADR_GRP_EN) ? 8'(grp_en_ff) :
    (wb_req.adr == ADR_GLOBAL) ? 8'(global_en_ff) : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
      stable_ff <= 3'h0;
      div4_ff <= '0;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      stable_ff <= nxt_stable;
      div4_ff <= div4_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < NUM_TICK; t++) begin
        clk_src_ff[t] <= SRC_RESET;
        tick_ctl_ff[t] <= CTL_RESET;
        tick_cnt_ff[t] <= '0;
      end
    end else begin
      for (int t = 0; t < NUM_TICK; t++) begin
        if (wr_clk_src[t]) begin
          clk_src_ff[t] <= wdat & clk_src_keep;
        end
        if (wr_tick_ctl[t]) begin
          tick_ctl_ff[t] <= wdat & ctl_keep;
        end
        if (!tick_run[t]) begin
          tick_cnt_ff[t] <= '0;
        end else if (psc_tick[t]) begin
          tick_cnt_ff[t] <= tick_cnt_ff[t] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_flag_ff <= '0;
      src_en_ff <= '0;
      grp_flag_ff <= '0;
      grp_en_ff <= '0;
      global_en_ff <= 1'b0;
      wake_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      src_flag_ff <= nxt_src_flag;
      grp_flag_ff <= nxt_grp_flag;
      global_en_ff <= nxt_global_en;
      if (wr_src_en) begin
        src_en_ff <= wdat;
      end
      if (wr_grp_en) begin
        grp_en_ff <= wdat[NUM_GRP-1:0];
      end
      wake_ff <= |(nxt_src_flag & ~src_flag_ff);
      irq_ff <= |(nxt_src_flag & src_en_ff);
    end
  end

  // One-cycle answer, dropped the cycle after
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_ff <= 1'b0;
      rd_dat_ff <= '0;
    end else begin
      wb_ack_ff <= bus_req;
      rd_dat_ff <= bus_req ? {24'h000000, rd_byte} : '0;
    end
  end

  assign wb_ack = wb_ack_ff;
  assign wb_dat_o = rd_dat_ff;
  assign wake = wake_ff;
  assign irq = irq_ff;

  // Assertions
  a_req_needs_enables:
  assert property (@(posedge clk) disable iff (!rst_n)
    irq_req |-> global_en_ff && !stack_full && grp_en_ff[irq_group]
      && |(src_active & GRP_MEMBERS[irq_group]))
    else $error("request without all enables");

  a_ack_clears_global:
  assert property (@(posedge clk) disable iff (!rst_n)
    (irq_ack && !irq_return) |=> !global_en_ff)
    else $error("service left global enable set");

  a_ack_keeps_source:
  assert property (@(posedge clk) disable iff (!rst_n)
    (irq_ack && !wr_src_flag) |=> ((src_flag_ff & $past(src_flag_ff)) == $past(src_flag_ff)))
    else $error("service cleared a source flag");

  a_cmp_edge_sets:
  assert property (@(posedge clk) disable iff (!rst_n)
    (sync2_ff[0] == sync3_ff[0] && sync3_ff[0] != stable_ff[0]) |=> src_flag_ff[SRC_CMP])
    else $error("comparator edge did not set flag");

  a_tick_ovf_sets:
  assert property (@(posedge clk) disable iff (!rst_n)
    tick_ovf[0] |=> src_flag_ff[SRC_TICK0] && tick_cnt_ff[0] == $past(tick_cnt_ff[0]) + 1'b1)
    else $error("tick overflow lost");

  a_tick_off_clear:
  assert property (@(posedge clk) disable iff (!rst_n)
    !tick_run[1] |=> tick_cnt_ff[1] == '0)
    else $error("disabled divider not cleared");

  a_reserved_reads_zero:
  assert property (@(posedge clk) disable iff (!rst_n)
    (wb_ack && $past(wb_req.adr) == ADR_TICK0_CTL) |-> wb_dat_o[6:3] == 4'h0)
    else $error("reserved control bits not zero");

  a_wake_on_rise:
  assert property (@(posedge clk) disable iff (!rst_n)
    |(src_flag_ff & ~$past(src_flag_ff)) |-> wake_ff)
    else $error("flag rise without wake");

  a_group_follows:
  assert property (@(posedge clk) disable iff (!rst_n)
    grp_set[2] |=> grp_flag_ff[2])
    else $error("group flag not set by member");

  a_period_sel:
  assert property (@(posedge clk) disable iff (!rst_n)
    tick_ovf[0] |-> tick_cnt_ff[0][PERIOD_BASE-1:0] == 8'hFF)
    else $error("overflow before 2^8 boundary");

  a_stack_blocks_req:
  assert property (@(posedge clk) disable iff (!rst_n)
    stack_full |-> !irq_req)
    else $error("request while stack full");

  a_ack_clears_group:
  assert property (@(posedge clk) disable iff (!rst_n)
    (irq_ack && !grp_set[irq_ack_group]) |=> !grp_flag_ff[$past(irq_ack_group)])
    else $error("service left group flag set");

  a_match_a_sets:
  assert property (@(posedge clk) disable iff (!rst_n)
    src_events.match_a |=> src_flag_ff[SRC_MATCH_A])
    else $error("match A did not set flag");

  a_match_p_sets:
  assert property (@(posedge clk) disable iff (!rst_n)
    src_events.match_p |=> src_flag_ff[SRC_MATCH_P])
    else $error("match P did not set flag");

  a_lv_rise_sets:
  assert property (@(posedge clk) disable iff (!rst_n)
    lv_rise |=> src_flag_ff[SRC_LV])
    else $error("low voltage did not set flag");

  a_nvm_done_sets:
  assert property (@(posedge clk) disable iff (!rst_n)
    src_events.nvm_done |=> src_flag_ff[SRC_NVM])
    else $error("memory completion did not set flag");

  a_serial_evt_sets:
  assert property (@(posedge clk) disable iff (!rst_n)
    serial_evt |=> src_flag_ff[SRC_SERIAL])
    else $error("serial event did not set flag");

  a_tick1_ovf_sets:
  assert property (@(posedge clk) disable iff (!rst_n)
    tick_ovf[1] |=> src_flag_ff[SRC_TICK1])
    else $error("tick 1 overflow lost");

  a_tick1_period:
  assert property (@(posedge clk) disable iff (!rst_n)
    tick_ovf[1] |-> tick_cnt_ff[1][PERIOD_BASE-1:0] == '1)
    else $error("tick 1 overflow before 2^8 boundary");

  a_tick0_off_clear:
  assert property (@(posedge clk) disable iff (!rst_n)
    !tick_run[0] |=> tick_cnt_ff[0] == '0)
    else $error("disabled tick 0 divider not cleared");

  a_src_sel_zero:
  assert property (@(posedge clk) disable iff (!rst_n)
    (wb_ack && $past(wb_req.adr) == ADR_TICK1_SRC) |-> wb_dat_o[7:SRC_SEL_W] == '0)
    else $error("reserved source select bits not zero");
endmodule

// ===== verification/core_model.sv
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq_req,
  input wire logic [1:0] irq_group,
  input wire logic [3:0] lat,
  input wire logic do_ret,
  output logic irq_ack,
  output logic [1:0] irq_ack_group,
  output logic irq_return,
  output logic [7:0] n_srv,
  output logic [1:0] last_grp
);
  logic [3:0] wait_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      irq_ack_group <= 2'h0;
      irq_return <= 1'b0;
      n_srv <= 8'h0;
      last_grp <= 2'h0;
      wait_ff <= 4'h0;
    end else begin
      irq_return <= do_ret;
      irq_ack <= 1'b0;
      // Group lines carry junk outside an acknowledge
      irq_ack_group <= ~irq_group;
      wait_ff <= (irq_req && !irq_ack) ? wait_ff + 4'h1 : 4'h0;
      if (irq_req && !irq_ack && wait_ff >= lat) begin
        irq_ack <= 1'b1;
        irq_ack_group <= irq_group;
        n_srv <= n_srv + 8'h1;
        last_grp <= irq_group;
        wait_ff <= 4'h0;
      end
    end
  end
endmodule

// ===== verification/periodic_tick_and_grouped_irq_sources_tb.sv
`timescale 1ns/1ps
module periodic_tick_and_grouped_irq_sources_tb;
  import tick_irq_pkg::*;
  logic clk, rst_n, cmp_out, low_voltage, sub_clk, stack_full, do_ret, wake_seen;
  logic wb_ack, irq_req, wake, irq, irq_ack, irq_return;
  logic [31:0] wb_dat_o, rd, grp;
  logic [1:0] irq_group, irq_ack_group, last_grp, sub_div;
  logic [7:0] n_srv;
  logic [3:0] lat;
  wb_req_t req;
  src_events_t ev;
  int n_errors, checks_done;
  localparam int BIT_OF [9] = '{0, 1, 2, 2, 5, 6, 7, 7, 7};

  tick_irq_ctrl DUT (.clk(clk), .rst_n(rst_n), .wb_req(req), .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o), .src_events(ev), .cmp_out(cmp_out), .low_voltage(low_voltage),
    .low_speed_subclk(sub_clk), .stack_full(stack_full), .irq_ack(irq_ack),
    .irq_ack_group(irq_ack_group), .irq_return(irq_return), .irq_req(irq_req),
    .irq_group(irq_group), .wake(wake), .irq(irq));
  core_model core (.clk(clk), .rst_n(rst_n), .irq_req(irq_req), .irq_group(irq_group),
    .lat(lat), .do_ret(do_ret), .irq_ack(irq_ack), .irq_ack_group(irq_ack_group),
    .irq_return(irq_return), .n_srv(n_srv), .last_grp(last_grp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Subclock of eight system cycles, free running
  always @(posedge clk) begin
    sub_div <= sub_div + 2'h1;
    if (sub_div == 2'h3) sub_clk <= ~sub_clk;
    if (wake === 1'b1) wake_seen <= 1'b1;
  end

  task automatic end_of_test;
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    i = 0;
    // Ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge clk);
      i++;
    end while (wb_ack !== 1'b1 && i < 20);
    check(32'(wb_ack), 32'h1);
    if (wb_ack !== 1'b1) end_of_test();
    rd = wb_dat_o;
    req <= '0;
  endtask
  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(rd, exp);
  endtask
  task automatic fire(input int k);
    src_events_t e;
    e = '0;
    e.match_a = (k == 0);
    e.match_p = (k == 1);
    e.nvm_done = (k == 5);
    e.byte_done = (k == 6);
    e.addr_match = (k == 7);
    e.bus_timeout = (k == 8);
    @(posedge clk);
    wake_seen <= 1'b0;
    ev <= e;
    if (k == 2 || k == 3) cmp_out <= ~cmp_out;
    if (k == 4) low_voltage <= 1'b1;
    @(posedge clk);
    ev <= '0;
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_srv(input logic [7:0] n);
    for (int i = 0; i < 100 && n_srv !== n; i++) @(negedge clk);
    check(32'(n_srv), 32'(n));
    if (n_srv !== n) end_of_test();
  endtask
  task automatic tick(input logic [7:0] sa, input logic [7:0] ca, input int b,
                      input logic [1:0] s, input logic [2:0] p, input int exp);
    int n;
    wb(1'b1, sa, {30'h0, s});
    // Partial run first: a stale divider would shorten the timed run
    wb(1'b1, ca, 32'h80);
    repeat (100) @(posedge clk);
    wb(1'b1, ca, 32'h0);
    wb(1'b1, ADR_SRC_FLAG, 32'hFF);
    wb(1'b1, ADR_SRC_EN, 32'h1 << b);
    wb(1'b1, ca, {24'h0, 5'h10, p});
    n = 0;
    while (irq !== 1'b1 && n < exp + 64) begin
      @(negedge clk);
      n++;
    end
    check(32'(n >= exp - 8 && n <= exp + 16), 32'h1);
    if (irq !== 1'b1) end_of_test();
    wb(1'b1, ca, 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    req = '0;
    ev = '0;
    {cmp_out, low_voltage, sub_clk, stack_full, do_ret, wake_seen} = 6'h0;
    sub_div = 2'h0;
    lat = 4'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rchk(8'(a), 32'h0);
    wb(1'b1, ADR_TICK0_SRC, 32'hFFFF_FFFF);
    rchk(ADR_TICK0_SRC, 32'h3);
    wb(1'b1, ADR_TICK1_CTL, 32'hFF);
    rchk(ADR_TICK1_CTL, 32'h87);
    wb(1'b1, ADR_TICK1_CTL, 32'h0);
    wb(1'b1, 8'h24, 32'hFF);
    rchk(8'h24, 32'h0);
    for (int k = 0; k < 9; k++) begin
      for (int g = 0; g < 4; g++) grp[g] = GRP_MEMBERS[g][BIT_OF[k]];
      grp[31:4] = '0;
      fire(k);
      check(32'(wake_seen), 32'h1);
      rchk(ADR_SRC_FLAG, 32'h1 << BIT_OF[k]);
      rchk(ADR_GRP_FLAG, grp);
      if (k == 4) low_voltage <= 1'b0;
      repeat (8) @(posedge clk);
      wb(1'b1, ADR_SRC_FLAG, 32'hFF);
      wb(1'b1, ADR_GRP_FLAG, 32'hF);
      rchk(ADR_SRC_FLAG, 32'h0);
    end
    wb(1'b1, ADR_SRC_EN, 32'h3);
    wb(1'b1, ADR_GRP_EN, 32'h1);
    wb(1'b1, ADR_GLOBAL, 32'h1);
    stack_full <= 1'b1;
    fire(0);
    check(32'(irq), 32'h1);
    check(32'(n_srv), 32'h0);
    stack_full <= 1'b0;
    wait_srv(8'h1);
    check(32'(last_grp), 32'h0);
    rchk(ADR_GLOBAL, 32'h0);
    rchk(ADR_GRP_FLAG, 32'h0);
    rchk(ADR_SRC_FLAG, 32'h1);
    lat <= 4'h6;
    fire(1);
    check(32'(n_srv), 32'h1);
    do_ret <= 1'b1;
    @(posedge clk);
    do_ret <= 1'b0;
    wait_srv(8'h2);
    check(32'(last_grp), 32'h0);
    // Groups 0 and 3 pending together: priority first, then a group 3 service
    wb(1'b1, ADR_SRC_FLAG, 32'hFF);
    wb(1'b1, ADR_SRC_EN, 32'h41);
    wb(1'b1, ADR_GRP_EN, 32'h9);
    lat <= 4'h0;
    fire(5);
    fire(0);
    wb(1'b1, ADR_GLOBAL, 32'h1);
    wait_srv(8'h3);
    check(32'(last_grp), 32'h0);
    rchk(ADR_GRP_FLAG, 32'h8);
    do_ret <= 1'b1;
    @(posedge clk);
    do_ret <= 1'b0;
    wait_srv(8'h4);
    check(32'(last_grp), 32'h3);
    rchk(ADR_GRP_FLAG, 32'h0);
    rchk(ADR_SRC_FLAG, 32'h41);
    wb(1'b1, ADR_SRC_EN, 32'h0);
    tick(ADR_TICK0_SRC, ADR_TICK0_CTL, SRC_TICK0, SEL_SYS, 3'h0, 256);
    tick(ADR_TICK0_SRC, ADR_TICK0_CTL, SRC_TICK0, SEL_SYS, 3'h7, 32768);
    tick(ADR_TICK0_SRC, ADR_TICK0_CTL, SRC_TICK0, 2'h3, 3'h0, 2048);
    tick(ADR_TICK1_SRC, ADR_TICK1_CTL, SRC_TICK1, SEL_SYS_DIV4, 3'h0, 1024);
    tick(ADR_TICK1_SRC, ADR_TICK1_CTL, SRC_TICK1, 2'h2, 3'h1, 4096);
    end_of_test();
  end
endmodule
